//--- logic/uart_irq_pkg.sv
package uart_irq_pkg;

  // bus shape
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_SRC = 7;

  // register offsets (byte addresses)
  localparam logic [11:0] OFS_MASK    = 12'h038;
  localparam logic [11:0] OFS_RAW     = 12'h03C;
  localparam logic [11:0] OFS_MIS     = 12'h040;
  localparam logic [11:0] OFS_CLR     = 12'h044;
  localparam logic [11:0] OFS_ID_LOW  = 12'hFD0;
  localparam logic [11:0] OFS_ID_MID  = 12'hFD4;
  localparam logic [11:0] OFS_ID_HIGH = 12'hFD8;

  // source bit positions, shared by status and clear views
  localparam int BIT_RX_LEVEL   = 4;
  localparam int BIT_TX_LEVEL   = 5;
  localparam int BIT_RX_TIMEOUT = 6;
  localparam int BIT_FRAMING    = 7;
  localparam int BIT_PARITY     = 8;
  localparam int BIT_BREAK      = 9;
  localparam int BIT_OVERRUN    = 10;
  localparam int SRC_LSB        = BIT_RX_LEVEL;
  localparam int SRC_MSB        = BIT_OVERRUN;

  // identification field
  localparam int ID_MSB = 7;

  // reset values
  localparam logic [6:0]  RST_FLAGS = 7'h00;
  localparam logic [31:0] RST_RDATA = 32'h00000000;

  // identification defaults; values are arbitrary
  localparam logic [7:0] ID_LOW_DFLT  = 8'hA5;
  localparam logic [7:0] ID_MID_DFLT  = 8'h5A;
  localparam logic [7:0] ID_HIGH_DFLT = 8'h3C;

  // read source selection
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_MASK,
    SEL_RAW,
    SEL_MIS,
    SEL_CLR,
    SEL_ID_LOW,
    SEL_ID_MID,
    SEL_ID_HIGH
  } reg_sel_t;

endpackage

//--- logic/irq_flag_cell.sv
`timescale 1ns/100ps
// one sticky interrupt flag; a set in the clear cycle wins
module irq_flag_cell (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // control
  input  wire logic set_pulse,
  input  wire logic clr_pulse,
  // state
  output logic      flag
);

  // set beats clear so an event is never lost
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flag <= 1'b0;
    end else if (set_pulse) begin
      flag <= 1'b1;
    end else if (clr_pulse) begin
      flag <= 1'b0;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_cell_set_wins: assert property (set_pulse |=> flag)
    else $error("flag lost an event");
  a_cell_clear_acts: assert property (clr_pulse && !set_pulse |=> !flag)
    else $error("flag not cleared");

endmodule

//--- logic/uart_irq_status_clear_id.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
// interrupt status, clear and identification registers
module uart_irq_status_clear_id
  import uart_irq_pkg::*;
#(
  parameter logic [7:0] IDENT_LOW  = ID_LOW_DFLT,
  parameter logic [7:0] IDENT_MID  = ID_MID_DFLT,
  parameter logic [7:0] IDENT_HIGH = ID_HIGH_DFLT
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              resetn,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // serial logic side
  input  wire logic [NUM_SRC-1:0] src_event,
  input  wire logic [NUM_SRC-1:0] interrupt_mask,
  output logic      [NUM_SRC-1:0] raw_flags,
  // to the system interrupt controller
  output logic                   irq_out
);

  // write decode
  logic                clr_write;
  logic [NUM_SRC-1:0]  clear_vec;

  // named clear strobes
  logic overrun_err_clr;
  logic break_err_clr;
  logic parity_err_clr;
  logic framing_err_clr;
  logic rx_timeout_clr;
  logic tx_level_clr;
  logic rx_level_clr;

  // masked view
  logic [NUM_SRC-1:0] masked_vec;
  logic overrun_err_masked;
  logic break_err_masked;
  logic parity_err_masked;
  logic framing_err_masked;
  logic rx_timeout_masked;
  logic tx_level_masked;
  logic rx_level_masked;

  // read path
  reg_sel_t            rd_sel;
  logic [DATA_W-1:0]   next_rdata;

  // only the clear register accepts writes; all others are read-only
  assign clr_write = reg_wr && (reg_addr == OFS_CLR);

  // each one bit in the clear word targets one source
  assign overrun_err_clr = clr_write && reg_wdata[BIT_OVERRUN];
  assign break_err_clr   = clr_write && reg_wdata[BIT_BREAK];
  assign parity_err_clr  = clr_write && reg_wdata[BIT_PARITY];
  assign framing_err_clr = clr_write && reg_wdata[BIT_FRAMING];
  assign rx_timeout_clr  = clr_write && reg_wdata[BIT_RX_TIMEOUT];
  assign tx_level_clr    = clr_write && reg_wdata[BIT_TX_LEVEL];
  assign rx_level_clr    = clr_write && reg_wdata[BIT_RX_LEVEL];

  // zero bits give no strobe, so untargeted flags hold
  assign clear_vec = {overrun_err_clr, break_err_clr, parity_err_clr,
                      framing_err_clr, rx_timeout_clr, tx_level_clr,
                      rx_level_clr};

  // one sticky flag per source
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
      irq_flag_cell u_cell (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .set_pulse (src_event[gi]),
        .clr_pulse (clear_vec[gi]),
        .flag      (raw_flags[gi])
      );
    end
  endgenerate

  // masking gates the raw flags; the raw flag itself is kept
  assign masked_vec = raw_flags & interrupt_mask;

  // named masked bits
  assign rx_level_masked    = masked_vec[0];
  assign tx_level_masked    = masked_vec[1];
  assign rx_timeout_masked  = masked_vec[2];
  assign framing_err_masked = masked_vec[3];
  assign parity_err_masked  = masked_vec[4];
  assign break_err_masked   = masked_vec[5];
  assign overrun_err_masked = masked_vec[6];

  // interrupt line, combinational so it drops in the clear cycle's next edge
  assign irq_out = overrun_err_masked | break_err_masked |
                   parity_err_masked | framing_err_masked |
                   rx_timeout_masked | tx_level_masked |
                   rx_level_masked;

  // read address decode
  always_comb begin
    case (reg_addr)
      OFS_MASK:    rd_sel = SEL_MASK;
      OFS_RAW:     rd_sel = SEL_RAW;
      OFS_MIS:     rd_sel = SEL_MIS;
      OFS_CLR:     rd_sel = SEL_CLR;
      OFS_ID_LOW:  rd_sel = SEL_ID_LOW;
      OFS_ID_MID:  rd_sel = SEL_ID_MID;
      OFS_ID_HIGH: rd_sel = SEL_ID_HIGH;
      default:     rd_sel = SEL_NONE;
    endcase
  end

  // read data mux; reserved bits and unmapped addresses give zero
  always_comb begin
    next_rdata = RST_RDATA;
    case (rd_sel)
      SEL_MASK: begin
        next_rdata[SRC_MSB:SRC_LSB] = interrupt_mask;
      end
      SEL_RAW: begin
        next_rdata[SRC_MSB:SRC_LSB] = raw_flags;
      end
      SEL_MIS: begin
        next_rdata[SRC_MSB:SRC_LSB] = masked_vec;
      end
      SEL_CLR: begin
        next_rdata = RST_RDATA;
      end
      SEL_ID_LOW: begin
        next_rdata[ID_MSB:0] = IDENT_LOW;
      end
      SEL_ID_MID: begin
        next_rdata[ID_MSB:0] = IDENT_MID;
      end
      SEL_ID_HIGH: begin
        next_rdata[ID_MSB:0] = IDENT_HIGH;
      end
      default: begin
        next_rdata = RST_RDATA;
      end
    endcase
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= RST_RDATA;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= RST_RDATA;
    end
  end

  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // write-one clears every targeted flag unless its event is coincident
  a_clear_one_drops: assert property (
    clr_write |=> (raw_flags & $past(clear_vec) & ~$past(src_event)) == 7'h00)
    else $error("written one did not clear flag");

  // untargeted flags keep their state plus any new events
  a_clear_zero_keeps: assert property (
    clr_write |=>
      ((raw_flags & ~$past(clear_vec)) ==
       (($past(raw_flags) | $past(src_event)) & ~$past(clear_vec))))
    else $error("written zero changed a flag");

  // overrun at bit ten
  a_overrun_clear_bit: assert property (
    reg_wr && reg_addr == OFS_CLR && reg_wdata[BIT_OVERRUN] && !src_event[6]
    |=> !raw_flags[6])
    else $error("overrun clear bit misplaced");

  // break at bit nine
  a_break_clear_bit: assert property (
    reg_wr && reg_addr == OFS_CLR && reg_wdata[BIT_BREAK] && !src_event[5]
    |=> !raw_flags[5])
    else $error("break clear bit misplaced");

  // flags and read data come out of reset clear
  a_flags_reset_zero: assert property (
    $rose(resetn) |-> raw_flags == 7'h00 && reg_rdata == 32'h00000000)
    else $error("flags not zero after reset");

  // parity at bit eight
  a_parity_clear_bit: assert property (
    reg_wr && reg_addr == OFS_CLR && reg_wdata[BIT_PARITY] && !src_event[4]
    |=> !raw_flags[4])
    else $error("parity clear bit misplaced");

  // framing at bit seven, only it drops on a single-bit write; a parity event may still land
  a_framing_clear_bit: assert property (
    reg_wr && reg_addr == OFS_CLR && reg_wdata == 32'h00000080 && raw_flags[3]
    && !src_event[3]
    |=> !raw_flags[3] && raw_flags[4] == ($past(raw_flags[4]) | $past(src_event[4])))
    else $error("framing clear bit misplaced");

  // receive time-out at bit six
  a_timeout_clear_bit: assert property (
    reg_wr && reg_addr == OFS_CLR && reg_wdata[BIT_RX_TIMEOUT] && !src_event[2]
    |=> !raw_flags[2])
    else $error("time-out clear bit misplaced");

  // transmit at bit five, receive at bit four
  a_level_clear_bits: assert property (
    reg_wr && reg_addr == OFS_CLR && reg_wdata[BIT_TX_LEVEL]
    && reg_wdata[BIT_RX_LEVEL] && src_event[1:0] == 2'h0
    |=> raw_flags[1:0] == 2'h0)
    else $error("level clear bits misplaced");

  // reserved bits of clear and masked views read zero
  a_reserved_zero: assert property (
    reg_rd && (reg_addr == OFS_CLR || reg_addr == OFS_MIS)
    |=> reg_rdata[31:11] == 21'h000000 && reg_rdata[3:0] == 4'h0)
    else $error("reserved bits not zero");

  // identification upper bits stay zero
  a_ident_upper_zero: assert property (
    reg_rd && (reg_addr == OFS_ID_LOW || reg_addr == OFS_ID_MID ||
               reg_addr == OFS_ID_HIGH)
    |=> reg_rdata[31:8] == 24'h000000)
    else $error("identification upper bits set");

  // the middle and high identification registers return their own fields
  a_ident_values: assert property (
    reg_rd && reg_addr == OFS_ID_MID ##1 reg_rd && reg_addr == OFS_ID_HIGH
    |-> reg_rdata[7:0] == IDENT_MID ##1 reg_rdata[7:0] == IDENT_HIGH)
    else $error("identification value wrong");

  // masked view sits at bits ten to four and matches raw and mask
  a_masked_read: assert property (
    reg_rd && reg_addr == OFS_MIS
    |=> reg_rdata[10:4] == ($past(raw_flags) & $past(interrupt_mask)))
    else $error("masked status read wrong");

  // writes to status views leave the flags alone
  a_status_write_ignored: assert property (
    reg_wr && (reg_addr == OFS_MIS || reg_addr == OFS_RAW) && src_event == 7'h00
    |=> raw_flags == $past(raw_flags))
    else $error("status write changed flags");

  // raw view shows flags regardless of mask
  a_raw_read: assert property (
    reg_rd && reg_addr == OFS_RAW |=> reg_rdata[10:4] == $past(raw_flags))
    else $error("raw status read wrong");

  // an unmasked event raises the line on the next edge
  a_mask_routes: assert property (
    (src_event & interrupt_mask) != 7'h00 ##1 interrupt_mask == $past(interrupt_mask)
    |-> irq_out)
    else $error("unmasked event not routed");

  // a blocked source alone never drives the line
  a_mask_blocks: assert property (
    interrupt_mask == 7'h00 |-> !irq_out)
    else $error("masked event reached line");

  // clearing the only pending masked source drops the line
  a_irq_drops: assert property (
    clr_write && clear_vec == masked_vec && masked_vec != 7'h00 && src_event == 7'h00
    ##1 interrupt_mask == $past(interrupt_mask) |-> !irq_out)
    else $error("line stayed after clear");

  // read data lasts one cycle only
  a_rdata_one_cycle: assert property (
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data held too long");

  // main scenarios
  c_clear_pending: cover property (raw_flags[6] && overrun_err_clr ##1 !raw_flags[6]);
  c_irq_rise: cover property (!irq_out ##1 irq_out);
  c_event_meets_clear: cover property (src_event[3] && framing_err_clr ##1 raw_flags[3]);
  c_ident_read: cover property (reg_rd && reg_addr == OFS_ID_HIGH);

endmodule

//--- bench/irq_ctrl_model.sv
`timescale 1ns/100ps
// stand-in for the system interrupt controller
module irq_ctrl_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic resetn,
  // request line
  input  wire logic irq,
  output logic      pending
);
  // sticky latch, so a request lasting one cycle is never lost
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pending <= 1'b0;
    end else if (irq) begin
      pending <= 1'b1;
    end
  end
endmodule

//--- bench/uart_irq_status_clear_id_test.sv
`timescale 1ns/100ps
module uart_irq_status_clear_id_test;
  import uart_irq_pkg::*;
  localparam logic [7:0] ID_L = 8'h96; // arbitrary
  localparam logic [7:0] ID_M = 8'h69; // arbitrary
  localparam logic [7:0] ID_H = 8'hC3; // arbitrary
  logic               clk_sys = 1'b0;
  logic               resetn = 1'b0;
  logic [ADDR_W-1:0]  reg_addr = '0;
  logic [DATA_W-1:0]  reg_wdata = '0;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [NUM_SRC-1:0] src_event = '0;
  logic [NUM_SRC-1:0] interrupt_mask = '0;
  logic [NUM_SRC-1:0] flags = '0;
  logic [NUM_SRC-1:0] e;
  logic [NUM_SRC-1:0] c;
  logic [DATA_W-1:0]  reg_rdata;
  logic [NUM_SRC-1:0] raw_flags;
  logic               irq_out;
  logic               pending;
  logic               rd_q = 1'b0;
  logic [DATA_W-1:0]  exp_q[$];
  logic [11:0]        ro_addr[5] = '{OFS_RAW, OFS_MIS, OFS_ID_LOW, OFS_MASK, 12'h100};
  int                 fails = 0;
  int                 compares = 0;
  int                 cycles = 0;

  always #4 clk_sys = ~clk_sys;

  uart_irq_status_clear_id #(.IDENT_LOW(ID_L), .IDENT_MID(ID_M), .IDENT_HIGH(ID_H)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .interrupt_mask(interrupt_mask), .raw_flags(raw_flags), .irq_out(irq_out));
  irq_ctrl_model u_ctrl (.clk_sys(clk_sys), .resetn(resetn), .irq(irq_out), .pending(pending));

  task automatic check(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // source flags placed at their register bit positions
  function automatic logic [DATA_W-1:0] view(input logic [NUM_SRC-1:0] v);
    return {21'h0, v, 4'h0};
  endfunction

  // one bus cycle; reads leave their expected word in the queue
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x);
    @(posedge clk_sys);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    src_event <= '0;
    if (!w) exp_q.push_back(x);
  endtask

  // release strobes, then step to mid-cycle where outputs are settled
  task automatic idle;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    src_event <= '0;
    @(negedge clk_sys);
  endtask

  task automatic ev(input logic [NUM_SRC-1:0] s, input logic [NUM_SRC-1:0] m);
    @(posedge clk_sys);
    src_event <= s;
    interrupt_mask <= m;
    flags |= s;
  endtask

  task automatic state;
    check("raw flags", {25'h0, flags}, {25'h0, raw_flags});
    check("irq line", {31'h0, |(flags & interrupt_mask)}, {31'h0, irq_out});
  endtask

  // read data watcher: one word in the cycle after each read, zero elsewhere
  always @(posedge clk_sys) rd_q <= reg_rd;
  always @(negedge clk_sys) begin
    if (rd_q && exp_q.size() > 0) check("read data", exp_q.pop_front(), reg_rdata);
    else if (resetn) check("idle data", '0, reg_rdata);
  end

  // hang guard, well above the length of the sequence
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      close_out;
    end
  end

  initial begin
    void'($urandom(32'hEBDF));
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    // reset views, identification and an unmapped hole, back to back
    bus(0, OFS_MIS, '0, '0);
    bus(0, OFS_RAW, '0, '0);
    bus(0, OFS_CLR, '0, '0);
    bus(0, OFS_ID_LOW, '0, {24'h0, ID_L});
    bus(0, OFS_ID_MID, '0, {24'h0, ID_M});
    bus(0, OFS_ID_HIGH, '0, {24'h0, ID_H});
    bus(0, 12'h100, '0, '0);
    idle;
    state;
    check("ctrl idle", 32'h0, {31'h0, pending});
    // every source pending and passed on
    ev(7'h7F, 7'h7F);
    idle;
    state;
    // the controller latches the line one edge after it rises
    @(negedge clk_sys);
    check("ctrl seen", 32'h1, {31'h0, pending});
    // writes to read-only places change nothing
    foreach (ro_addr[i]) bus(1, ro_addr[i], 32'hFFFFFFFF, '0);
    interrupt_mask <= 7'h55;
    bus(0, OFS_MASK, '0, view(7'h55));
    bus(0, OFS_RAW, '0, view(7'h7F));
    bus(0, OFS_MIS, '0, view(7'h55));
    bus(0, OFS_ID_LOW, '0, {24'h0, ID_L});
    idle;
    state;
    // writing zeros, even with reserved bits set, clears nothing
    bus(1, OFS_CLR, 32'hFFFFF80F, '0);
    idle;
    state;
    // clear one source at a time; the others stay pending
    for (int i = 0; i < NUM_SRC; i++) begin
      bus(1, OFS_CLR, 32'hFFFFF80F | (32'h10 << i), '0);
      flags[i] = 1'b0;
      bus(0, OFS_MIS, '0, view(flags & 7'h55));
      idle;
      state;
    end
    // an event in the clearing cycle wins
    @(posedge clk_sys);
    src_event <= 7'h08;
    reg_wr <= 1'b1;
    reg_addr <= OFS_CLR;
    reg_wdata <= 32'h80;
    flags = 7'h08;
    idle;
    state;
    // random traffic: events, mask and clears, read back at once
    repeat (40) begin
      e = NUM_SRC'($urandom);
      c = NUM_SRC'($urandom);
      ev(e, NUM_SRC'($urandom));
      bus(1, OFS_CLR, view(c), '0);
      flags &= ~c;
      bus(0, OFS_MIS, '0, view(flags & interrupt_mask));
      idle;
      state;
    end
    close_out;
  end
endmodule
